// ==== include/iopcn_pkg.sv ====
// Purpose: Shared constants for the I/O port, change notice and pin routing block.
// Assumes: 32-bit register words at byte addresses on a plain strobe port.
// Notes:   Routing selects sit in two separate windows of the map.
package iopcn_pkg;

  // ==========================================================================
  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] OFS_DIRECTION    = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h04;
  localparam logic [7:0] OFS_PIN_LEVEL    = 8'h08;
  localparam logic [7:0] OFS_ANALOG_SEL   = 8'h0C;
  localparam logic [7:0] OFS_CHANGE_CTRL  = 8'h10;
  localparam logic [7:0] OFS_CHG_EN_FIRST = 8'h14;
  localparam logic [7:0] OFS_CHG_EN_SECND = 8'h18;
  localparam logic [7:0] OFS_CHG_STATUS   = 8'h1C;
  localparam logic [7:0] OFS_CHG_FLAG     = 8'h20;
  localparam logic [7:0] OFS_PULL_UP      = 8'h24;
  localparam logic [7:0] OFS_PULL_DOWN    = 8'h28;
  localparam logic [7:0] OFS_ROUTING_CTRL = 8'h2C;
  localparam logic [7:0] OFS_IN_ROUTE     = 8'h40;
  localparam logic [7:0] OFS_OUT_ROUTE    = 8'h80;
  localparam logic [7:0] ROUTE_WIN_MASK   = 8'hC0;

  // ==========================================================================
  // Field positions and widths
  localparam int unsigned CC_ENABLE_BIT  = 15;
  localparam int unsigned CC_STYLE_BIT   = 11;
  localparam int unsigned RC_LOCK_BIT    = 0;
  localparam int unsigned IN_SEL_W       = 5;
  localparam int unsigned OUT_SEL_W      = 4;

  // ==========================================================================
  // Reset values and timing
  localparam logic [31:0] ANALOG_SEL_RST = 32'h0000FFFF;
  localparam logic [31:0] DIRECTION_RST  = 32'hFFFFFFFF;
  localparam int unsigned PIN_SYNC_STAGES = 3;

endpackage

// ==== rtl/iopcn_port.sv ====
// Purpose: One I/O port with analog select, change notice, weak pulls and pin routing.
// Assumes: Pin inputs are synchronous to clk; routed pins are port pins 0 upward.
// Notes:   Remappable pin number n is port pin n-1; number 0 selects no pin.
//
// Overview of operation
// - Pin level reads zero for every pin set up as analog input.
// - Analog select resets to ones on pins 0 to 15, so those pins start analog.
// - Output direction with analog select still drives the latch level.
// - Change detection runs without any bus activity, for wake from sleep.
// - Change notice works only while change control bit 15 is set; change status still updates while it is clear.
// - Style zero: first enable flags mismatch versus last read state.
// - Style one: enable pair selects rising, falling or both edges.
// - Change status shows change since last pin level read.
// - Event flag sets on the selected event and stays until cleared.
// - Only pins with direction input raise change notice interrupts.
// - Each pin has separate weak pull-up and pull-down enables.
// - Routed peripherals have no default pin until software assigns one.
// - Routed peripheral overrides general I/O and fixed digital functions.
// - Analog selection keeps precedence over routing.
// - Input routing and output routing use separate register sets.
// - Each peripheral input has a 5-bit pin number select.
// - Each remappable pin has a 4-bit output select, zero unconnected.
// - While routing lock is set, routing select writes are ignored.
// - Pin level lags the pins by three clock cycles.
// - Direction one means input; all pins input after reset.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps

module iopcn_port
  import iopcn_pkg::*;
#(
  parameter int unsigned NUM_PINS = 16,
  parameter int unsigned NUM_RP   = 8,
  parameter int unsigned NUM_RIN  = 4,
  parameter int unsigned NUM_ROUT = 9
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [DATA_W-1:0]     reg_wdata,
  input  wire logic                  reg_we,
  input  wire logic                  reg_re,
  output logic      [DATA_W-1:0]     reg_rdata,
  // Pads
  input  wire logic [NUM_PINS-1:0]   pad_in,
  output logic      [NUM_PINS-1:0]   pad_out,
  output logic      [NUM_PINS-1:0]   pad_oe,
  output logic      [NUM_PINS-1:0]   weak_pull_up_enable,
  output logic      [NUM_PINS-1:0]   weak_pull_down_enable,
  // Fixed digital functions sharing the pins
  input  wire logic [NUM_PINS-1:0]   fixed_fn_en,
  input  wire logic [NUM_PINS-1:0]   fixed_fn_out,
  input  wire logic [NUM_PINS-1:0]   fixed_fn_oe,
  // Routed peripheral signals
  input  wire logic [NUM_ROUT-1:0]   periph_out,
  output logic      [NUM_RIN-1:0]    periph_in,
  // Interrupt request
  output logic                       input_change_notice_irq
);

  // ==========================================================================
  // Registers
  logic [NUM_PINS-1:0]  direction_register_q;
  logic [NUM_PINS-1:0]  output_latch_q;
  logic [NUM_PINS-1:0]  analog_select_q;
  logic                 cn_on_q;
  logic                 edge_style_select_q;
  logic [NUM_PINS-1:0]  change_enable_first_q;
  logic [NUM_PINS-1:0]  change_enable_second_q;
  logic [NUM_PINS-1:0]  change_status_q;
  logic [NUM_PINS-1:0]  change_event_flag_q;
  logic [NUM_PINS-1:0]  pull_up_q;
  logic [NUM_PINS-1:0]  pull_down_q;
  logic                 routing_lock_q;
  logic [IN_SEL_W-1:0]  input_route_select_q [NUM_RIN];
  logic [OUT_SEL_W-1:0] output_route_select_q [NUM_RP];
  logic [NUM_PINS-1:0]  sync_q [PIN_SYNC_STAGES];
  logic [NUM_PINS-1:0]  prev_level_q;
  logic [NUM_PINS-1:0]  last_read_q;
  logic [NUM_PINS-1:0]  level;
  logic [NUM_PINS-1:0]  analog_in;
  logic [NUM_PINS-1:0]  pin_level_view;
  logic [NUM_PINS-1:0]  rise;
  logic [NUM_PINS-1:0]  fall;
  logic [NUM_PINS-1:0]  event_hit;
  logic [NUM_PINS-1:0]  irq_src;
  logic                 wr_route;
  logic                 pin_read;
  function automatic logic is_addr(input logic [ADDR_W-1:0] ofs);
    is_addr = (reg_addr == ofs);
  endfunction
  // A remappable pin number maps to port pin number minus one.
  function automatic logic route_in(input logic [IN_SEL_W-1:0] sel, input logic [NUM_PINS-1:0] lv);
    route_in = 1'b0;
    for (int p = 0; p < NUM_RP; p++) begin
      if (sel == IN_SEL_W'(p + 1)) begin
        route_in = lv[p];
      end
    end
  endfunction

  // ==========================================================================
  // Pin synchroniser and derived views
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < PIN_SYNC_STAGES; s++) begin
        sync_q[s] <= '0;
      end
      prev_level_q <= '0;
    end else begin
      sync_q[0] <= pad_in;
      for (int s = 1; s < PIN_SYNC_STAGES; s++) begin
        sync_q[s] <= sync_q[s-1];
      end
      // Edges compare masked views, so an analog pin held high never looks like a change.
      prev_level_q <= pin_level_view;
    end
  end
  assign level          = sync_q[PIN_SYNC_STAGES-1];
  assign analog_in      = analog_select_q & direction_register_q;
  assign pin_level_view = level & ~analog_in;
  assign rise           = pin_level_view & ~prev_level_q;
  assign fall           = ~pin_level_view & prev_level_q;
  assign pin_read       = reg_re && is_addr(OFS_PIN_LEVEL);
  assign wr_route       = reg_we && !routing_lock_q;
  // Event selection per pin; the second enable is ignored in mismatch style.
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!edge_style_select_q) begin
        event_hit[i] = change_enable_first_q[i] && (pin_level_view[i] != last_read_q[i]);
      end else begin
        event_hit[i] = (change_enable_first_q[i] && rise[i])
                     || (change_enable_second_q[i] && fall[i]);
      end
    end
  end
  // Only enabled input pins contribute to the request.
  assign irq_src = change_event_flag_q & direction_register_q
                 & (change_enable_first_q | (change_enable_second_q & {NUM_PINS{edge_style_select_q}}));

  // ==========================================================================
  // Port configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      direction_register_q <= DIRECTION_RST[NUM_PINS-1:0];
      output_latch_q       <= '0;
      analog_select_q      <= ANALOG_SEL_RST[NUM_PINS-1:0];
      pull_up_q            <= '0;
      pull_down_q          <= '0;
    end else if (reg_we) begin
      if (is_addr(OFS_DIRECTION))    direction_register_q <= reg_wdata[NUM_PINS-1:0];
      if (is_addr(OFS_OUTPUT_LATCH)) output_latch_q       <= reg_wdata[NUM_PINS-1:0];
      if (is_addr(OFS_ANALOG_SEL))   analog_select_q      <= reg_wdata[NUM_PINS-1:0];
      if (is_addr(OFS_PULL_UP))      pull_up_q            <= reg_wdata[NUM_PINS-1:0];
      if (is_addr(OFS_PULL_DOWN))    pull_down_q          <= reg_wdata[NUM_PINS-1:0];
    end
  end

  // ==========================================================================
  // Change notice control and enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cn_on_q                <= 1'b0;
      edge_style_select_q    <= 1'b0;
      change_enable_first_q  <= '0;
      change_enable_second_q <= '0;
    end else if (reg_we) begin
      if (is_addr(OFS_CHANGE_CTRL)) begin
        cn_on_q             <= reg_wdata[CC_ENABLE_BIT];
        edge_style_select_q <= reg_wdata[CC_STYLE_BIT];
      end
      if (is_addr(OFS_CHG_EN_FIRST)) change_enable_first_q  <= reg_wdata[NUM_PINS-1:0];
      if (is_addr(OFS_CHG_EN_SECND)) change_enable_second_q <= reg_wdata[NUM_PINS-1:0];
    end
  end

  // ==========================================================================
  // Change status and last read state
  // Detection looks only at sampled pin levels, so it needs no bus traffic to run.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      change_status_q <= '0;
      last_read_q     <= '0;
    end else begin
      if (pin_read) begin
        last_read_q <= pin_level_view;
      end
      // A change landing in the read cycle survives the clear.
      change_status_q <= (pin_read ? '0 : change_status_q)
                       | (pin_level_view ^ prev_level_q);
    end
  end

  // ==========================================================================
  // Event flags; a new event beats a software clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      change_event_flag_q     <= '0;
      input_change_notice_irq <= 1'b0;
    end else begin
      change_event_flag_q <= ((reg_we && is_addr(OFS_CHG_FLAG)) ? reg_wdata[NUM_PINS-1:0] : change_event_flag_q)
                           | (event_hit & {NUM_PINS{cn_on_q}});
      input_change_notice_irq <= cn_on_q && (|irq_src);
    end
  end

  // ==========================================================================
  // Routing selects, held apart for inputs and outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      routing_lock_q <= 1'b0;
    end else if (reg_we && is_addr(OFS_ROUTING_CTRL)) begin
      routing_lock_q <= reg_wdata[RC_LOCK_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int j = 0; j < NUM_RIN; j++) begin
        input_route_select_q[j] <= '0;
      end
    end else if (wr_route) begin
      for (int j = 0; j < NUM_RIN; j++) begin
        if (is_addr(OFS_IN_ROUTE + ADDR_W'(4 * j))) begin
          input_route_select_q[j] <= reg_wdata[IN_SEL_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_RP; k++) begin
        output_route_select_q[k] <= '0;
      end
    end else if (wr_route) begin
      for (int k = 0; k < NUM_RP; k++) begin
        if (is_addr(OFS_OUT_ROUTE + ADDR_W'(4 * k))) begin
          output_route_select_q[k] <= reg_wdata[OUT_SEL_W-1:0];
        end
      end
    end
  end
  // Analog input pins present zero to routed inputs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_in <= '0;
    end else begin
      for (int j = 0; j < NUM_RIN; j++) begin
        periph_in[j] <= route_in(input_route_select_q[j], pin_level_view);
      end
    end
  end

  // ==========================================================================
  // Pad drive: analog, then routed output, then fixed function, then latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= '0;
      pad_oe  <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        logic [OUT_SEL_W-1:0] code;
        code = '0;
        if (i < NUM_RP) begin
          code = output_route_select_q[i];
        end
        if (analog_select_q[i]) begin
          pad_out[i] <= output_latch_q[i];
          pad_oe[i]  <= ~direction_register_q[i];
        end else if (code != '0 && int'(code) <= NUM_ROUT) begin
          pad_out[i] <= periph_out[int'(code) - 1];
          pad_oe[i]  <= 1'b1;
        end else if (fixed_fn_en[i]) begin
          pad_out[i] <= fixed_fn_out[i];
          pad_oe[i]  <= fixed_fn_oe[i];
        end else begin
          pad_out[i] <= output_latch_q[i];
          pad_oe[i]  <= ~direction_register_q[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      weak_pull_up_enable   <= '0;
      weak_pull_down_enable <= '0;
    end else begin
      weak_pull_up_enable   <= pull_up_q;
      weak_pull_down_enable <= pull_down_q;
    end
  end

  // ==========================================================================
  // Read data, registered on the cycle after the read strobe and held until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_re) begin
      reg_rdata <= '0;
      unique case (reg_addr)
        OFS_DIRECTION:    reg_rdata[NUM_PINS-1:0] <= direction_register_q;
        OFS_OUTPUT_LATCH: reg_rdata[NUM_PINS-1:0] <= output_latch_q;
        OFS_PIN_LEVEL:    reg_rdata[NUM_PINS-1:0] <= pin_level_view;
        OFS_ANALOG_SEL:   reg_rdata[NUM_PINS-1:0] <= analog_select_q;
        OFS_CHANGE_CTRL: begin
          reg_rdata[CC_ENABLE_BIT] <= cn_on_q;
          reg_rdata[CC_STYLE_BIT]  <= edge_style_select_q;
        end
        OFS_CHG_EN_FIRST: reg_rdata[NUM_PINS-1:0] <= change_enable_first_q;
        OFS_CHG_EN_SECND: reg_rdata[NUM_PINS-1:0] <= change_enable_second_q;
        OFS_CHG_STATUS:   reg_rdata[NUM_PINS-1:0] <= change_status_q;
        OFS_CHG_FLAG:     reg_rdata[NUM_PINS-1:0] <= change_event_flag_q;
        OFS_PULL_UP:      reg_rdata[NUM_PINS-1:0] <= pull_up_q;
        OFS_PULL_DOWN:    reg_rdata[NUM_PINS-1:0] <= pull_down_q;
        OFS_ROUTING_CTRL: reg_rdata[RC_LOCK_BIT]   <= routing_lock_q;
        default: begin
          for (int j = 0; j < NUM_RIN; j++) begin
            if (is_addr(OFS_IN_ROUTE + ADDR_W'(4 * j))) begin
              reg_rdata[IN_SEL_W-1:0] <= input_route_select_q[j];
            end
          end
          for (int k = 0; k < NUM_RP; k++) begin
            if (is_addr(OFS_OUT_ROUTE + ADDR_W'(4 * k))) begin
              reg_rdata[OUT_SEL_W-1:0] <= output_route_select_q[k];
            end
          end
        end
      endcase
    end
  end
endmodule

// ==== test/iopcn_port_checker.sv ====
// Purpose: Port-level checks for the I/O port block.
// Assumes: Register traffic keeps the strobe port protocol.
// Notes:   Mirrors direction, latch and analog select from bus writes.
`timescale 1ns/100ps

module iopcn_port_checker
  import iopcn_pkg::*;
#(
  parameter int unsigned NUM_PINS = 16
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Register port
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_we,
  input wire logic                reg_re,
  input wire logic [DATA_W-1:0]   reg_rdata,
  // Pads and request
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic [NUM_PINS-1:0] weak_pull_up_enable,
  input wire logic [NUM_PINS-1:0] weak_pull_down_enable,
  input wire logic                input_change_notice_irq
);
  // ====================
  // Register mirrors
  logic [NUM_PINS-1:0] dir_q;
  logic [NUM_PINS-1:0] lat_q;
  logic [NUM_PINS-1:0] ana_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= NUM_PINS'(DIRECTION_RST);
      lat_q <= '0;
      ana_q <= NUM_PINS'(ANALOG_SEL_RST);
    end else if (reg_we) begin
      if (reg_addr == OFS_DIRECTION) dir_q <= reg_wdata[NUM_PINS-1:0];
      if (reg_addr == OFS_OUTPUT_LATCH) lat_q <= reg_wdata[NUM_PINS-1:0];
      if (reg_addr == OFS_ANALOG_SEL) ana_q <= reg_wdata[NUM_PINS-1:0];
    end
  end

  // ====================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_oe_reset;
    $rose(rst_n) |-> pad_oe == '0;
  endproperty
  a_oe_reset: assert property (p_oe_reset) else $error("pad driven right after reset");
  property p_pull_up;
    (reg_we && reg_addr == OFS_PULL_UP) |=> ##1 weak_pull_up_enable == $past(reg_wdata[NUM_PINS-1:0], 2);
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("pull-up enables differ from write");
  property p_pull_down;
    (reg_we && reg_addr == OFS_PULL_DOWN) |=> ##1 weak_pull_down_enable == $past(reg_wdata[NUM_PINS-1:0], 2);
  endproperty
  a_pull_down: assert property (p_pull_down) else $error("pull-down enables differ from write");
  property p_dir_gate;
    (reg_we && reg_addr == OFS_DIRECTION && reg_wdata[NUM_PINS-1:0] == '0) |=> ##1 !input_change_notice_irq;
  endproperty
  a_dir_gate: assert property (p_dir_gate) else $error("request with all pins output");
  property p_on_gate;
    (reg_we && reg_addr == OFS_CHANGE_CTRL && !reg_wdata[CC_ENABLE_BIT]) |=> ##1 !input_change_notice_irq;
  endproperty
  a_on_gate: assert property (p_on_gate) else $error("request with change notice off");
  property p_analog_read;
    (reg_re && reg_addr == OFS_PIN_LEVEL) |=>
      (reg_rdata[NUM_PINS-1:0] & $past(ana_q) & $past(dir_q)) == '0 && reg_rdata[DATA_W-1:NUM_PINS] == '0;
  endproperty
  a_analog_read: assert property (p_analog_read) else $error("analog input pin reads high");
  property p_anasel_read;
    (reg_re && reg_addr == OFS_ANALOG_SEL) |=> reg_rdata == DATA_W'(ana_q);
  endproperty
  a_anasel_read: assert property (p_anasel_read) else $error("analog select readback wrong");
  property p_analog_oe;
    ((pad_oe ^ ~$past(dir_q)) & $past(ana_q)) == '0;
  endproperty
  a_analog_oe: assert property (p_analog_oe) else $error("analog pin enable not from direction");
  property p_analog_out;
    ((pad_out ^ $past(lat_q)) & $past(ana_q) & ~$past(dir_q)) == '0;
  endproperty
  a_analog_out: assert property (p_analog_out) else $error("analog output pin not at latch");
endmodule

bind iopcn_port iopcn_port_checker #(.NUM_PINS(NUM_PINS)) u_iopcn_chk (
  .clk                     (clk),
  .rst_n                   (rst_n),
  .reg_addr                (reg_addr),
  .reg_wdata               (reg_wdata),
  .reg_we                  (reg_we),
  .reg_re                  (reg_re),
  .reg_rdata               (reg_rdata),
  .pad_out                 (pad_out),
  .pad_oe                  (pad_oe),
  .weak_pull_up_enable     (weak_pull_up_enable),
  .weak_pull_down_enable   (weak_pull_down_enable),
  .input_change_notice_irq (input_change_notice_irq)
);

// ==== test/iopcn_pin_world.sv ====
// Purpose: External pin model facing the I/O port.
// Assumes: One level per pin from the bench when it drives.
// Notes:   An undriven pin with no pull toggles every cycle.
`timescale 1ns/100ps

module iopcn_pin_world #(
  parameter int unsigned NUM_PINS = 16
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [NUM_PINS-1:0] pad_out,
  input wire logic [NUM_PINS-1:0] pad_oe,
  input wire logic [NUM_PINS-1:0] pull_up,
  input wire logic [NUM_PINS-1:0] pull_down,
  input wire logic [NUM_PINS-1:0] ext_lvl,
  input wire logic [NUM_PINS-1:0] ext_drv,
  output logic     [NUM_PINS-1:0] pad_in
);
  logic [NUM_PINS-1:0] float_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) float_q <= '0;
    else float_q <= ~float_q;
  end

  // A floating pin must not settle, so stale levels cannot pass for real ones.
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_drv[i] ? ext_lvl[i] :
                  pull_up[i] ? 1'b1 : pull_down[i] ? 1'b0 : float_q[i];
    end
  end
endmodule

// ==== test/iopcn_port_test.sv ====
// Purpose: Register-level tests of the I/O port block.
// Assumes: Default pin and routing counts.
// Notes:   Pin levels come from the external pin model.
`timescale 1ns/100ps

module iopcn_port_test
  import iopcn_pkg::*;
;
  logic        clk, rst_n, reg_we, reg_re, irq;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] pad_in, pad_out, pad_oe, pu, pd, fx_en, fx_out, fx_oe, ext_lvl, ext_drv;
  logic [8:0]  periph_out;
  logic [3:0]  periph_in;
  int          err_count, checks_done;

  iopcn_port DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .weak_pull_up_enable(pu), .weak_pull_down_enable(pd), .fixed_fn_en(fx_en), .fixed_fn_out(fx_out),
    .fixed_fn_oe(fx_oe), .periph_out(periph_out), .periph_in(periph_in), .input_change_notice_irq(irq));
  iopcn_pin_world u_world (.clk(clk), .rst_n(rst_n), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up(pu),
    .pull_down(pd), .ext_lvl(ext_lvl), .ext_drv(ext_drv), .pad_in(pad_in));

  always #25 clk = ~clk;

  // ====================
  // Bus and check tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    finish_test();
  end

  // ====================
  // Test sequence
  initial begin
    {clk, rst_n, reg_we, reg_re, reg_addr, reg_wdata} = '0;
    {fx_en, fx_out, fx_oe, periph_out} = '0;
    ext_drv = '1;
    ext_lvl = '1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_DIRECTION, 32'h0000FFFF);
    rd(OFS_ANALOG_SEL, ANALOG_SEL_RST);
    rd(8'h30, 32'h0);
    rd(OFS_PIN_LEVEL, 32'h0);
    wr(OFS_OUTPUT_LATCH, 32'h1);
    wr(OFS_DIRECTION, 32'hFFFE);
    waitc(3);
    chk(32'({pad_oe[0], pad_out[0]}), 32'h3);
    wr(OFS_DIRECTION, 32'hFFFF);
    wr(OFS_ANALOG_SEL, 32'h00FF);
    rd(OFS_PIN_LEVEL, 32'h0000FF00);
    wr(OFS_ANALOG_SEL, 32'h0);
    ext_lvl <= 16'h0000;
    rd(OFS_PIN_LEVEL, 32'h0000FFFF);
    waitc(3);
    rd(OFS_PIN_LEVEL, 32'h0);
    wr(OFS_PULL_UP, 32'h5A5A);
    wr(OFS_PULL_DOWN, 32'h0F0F);
    rd(OFS_PULL_UP, 32'h5A5A);
    chk(32'(pd), 32'h0F0F);
    ext_lvl <= 16'hFFFF;
    waitc(6);
    chk(32'(periph_in), 32'h0);
    wr(OFS_IN_ROUTE, 32'h3);
    waitc(6);
    chk(32'(periph_in), 32'h1);
    ext_lvl[2] <= 1'b0;
    waitc(6);
    chk(32'(periph_in), 32'h0);
    wr(OFS_ROUTING_CTRL, 32'h1);
    wr(OFS_IN_ROUTE, 32'h5);
    wr(OFS_OUT_ROUTE, 32'h2);
    rd(OFS_IN_ROUTE, 32'h3);
    rd(OFS_OUT_ROUTE, 32'h0);
    wr(OFS_ROUTING_CTRL, 32'h0);
    fx_en <= 16'h0002;
    fx_oe <= 16'h0002;
    for (int c = 1; c <= 9; c++) begin
      wr(OFS_OUT_ROUTE + 8'h04, 32'(c));
      periph_out <= 9'(1 << (c - 1));
      waitc(3);
      chk(32'({pad_oe[1], pad_out[1]}), 32'h3);
      periph_out <= ~9'(1 << (c - 1));
      waitc(3);
      chk(32'({pad_oe[1], pad_out[1]}), 32'h2);
    end
    rd(OFS_IN_ROUTE, 32'h3);
    wr(OFS_ANALOG_SEL, 32'h0002);
    waitc(3);
    chk(32'(pad_oe[1]), 32'h0);
    wr(OFS_ANALOG_SEL, 32'h0);
    wr(OFS_OUT_ROUTE + 8'h04, 32'h0);
    waitc(3);
    chk(32'({pad_oe[1], pad_out[1]}), 32'h2);
    fx_en <= '0;
    ext_lvl[0] <= 1'b0;
    wr(OFS_CHANGE_CTRL, 32'h8800);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CHG_EN_FIRST, 32'(m & 1));
      wr(OFS_CHG_EN_SECND, 32'(m >> 1));
      wr(OFS_CHG_FLAG, 32'h0);
      ext_lvl[0] <= 1'b1;
      waitc(8);
      chk(32'(irq), 32'(m & 1));
      rd(OFS_CHG_FLAG, 32'(m & 1));
      wr(OFS_CHG_FLAG, 32'h0);
      ext_lvl[0] <= 1'b0;
      waitc(8);
      rd(OFS_CHG_FLAG, 32'(m >> 1));
      wr(OFS_CHG_FLAG, 32'h0);
    end
    wr(OFS_CHG_EN_FIRST, 32'h1);
    wr(OFS_CHG_EN_SECND, 32'h0);
    ext_lvl[0] <= 1'b1;
    waitc(8);
    wr(OFS_DIRECTION, 32'h0);
    waitc(3);
    chk(32'(irq), 32'h0);
    rd(OFS_CHG_FLAG, 32'h1);
    wr(OFS_DIRECTION, 32'hFFFF);
    waitc(3);
    chk(32'(irq), 32'h1);
    wr(OFS_CHANGE_CTRL, 32'h0800);
    wr(OFS_CHG_FLAG, 32'h0);
    ext_lvl[0] <= 1'b0;
    waitc(6);
    ext_lvl[0] <= 1'b1;
    waitc(8);
    rd(OFS_CHG_FLAG, 32'h0);
    wr(OFS_CHG_EN_FIRST, 32'h0);
    wr(OFS_CHG_EN_SECND, 32'h1);
    wr(OFS_CHANGE_CTRL, 32'h8000);
    rd(OFS_PIN_LEVEL, 32'h0000FFFB);
    ext_lvl[0] <= 1'b0;
    waitc(8);
    rd(OFS_CHG_FLAG, 32'h0);
    rd(OFS_CHG_STATUS, 32'h1);
    wr(OFS_CHG_EN_FIRST, 32'h1);
    waitc(3);
    rd(OFS_CHG_FLAG, 32'h1);
    rd(OFS_PIN_LEVEL, 32'h0000FFFA);
    rd(OFS_CHG_STATUS, 32'h0);
    wr(OFS_CHG_FLAG, 32'h0);
    waitc(3);
    rd(OFS_CHG_FLAG, 32'h0);
    chk(32'(irq), 32'h0);
    finish_test();
  end
endmodule
